// [rcms_top.sv]
// reference clock monitor, selector, hold-off counter and channel dividers
// assumes: all inputs synchronous to mclk; vcxo_tick is a one-cycle enable
`timescale 1ns/1ps
`include "rcms_consts.svh"
module rcms_top
   import rcms_pkg::*;
(
   // clock and reset
   input  wire logic                  mclk,
   input  wire logic                  rst,
   // monitored inputs
   input  wire logic [3:0]            clk_in,
   input  wire logic [3:0]            diff_zero,
   // loss reference divider
   input  wire logic [8:0]            loss_reference_divider,
   input  wire logic                  loss_ref_divider_powerdown,
   input  wire logic [7:0]            validation_edge_count,
   input  wire logic                  monitor_flag_block,
   // selection control
   input  wire logic [1:0]            selection_mode_field,
   input  wire logic [1:0]            host_select,
   input  wire logic [7:0]            input_priority,
   input  wire logic                  revertive_enable,
   input  wire logic                  first_pll_bypass,
   // hold-off counter
   input  wire logic                  vcxo_tick,
   input  wire logic [17:0]           holdoff_prescaler_ratio,
   input  wire logic [7:0]            holdoff_start_value,
   // sticky clears, one-cycle pulses
   input  wire logic [3:0]            input_loss_clear,
   input  wire logic                  active_ref_clear,
   // holdover frequency word
   input  wire logic [15:0]           pll_freq_word,
   output logic [15:0]                holdover_freq_word,
   // status
   output rcms_status_t               status,
   output logic [3:0]                 input_loss_status,
   output logic [3:0]                 input_loss_sticky,
   // channel dividers
   input  wire logic [39:0]           channel_output_divider,
   output logic [4:0]                 channel_tick
);
   function automatic logic [1:0] prio_of(input logic [7:0] p, input logic [1:0] i);
      prio_of = p[2*i +: 2];
   endfunction

   // highest priority valid input, lowest index on a tie
   function automatic logic [2:0] best_valid(input logic [7:0] p, input logic [3:0] ok);
      logic [2:0] b;
      b = 3'h4;
      for (int i = 0; i < `RCMS_NUM_IN; i++) begin
         if (ok[i] && (b[2] || p[2*i +: 2] > p[2*b[1:0] +: 2]))
            b = {1'b0, 2'(i)};
      end
      best_valid = b;
   endfunction

   // out-of-range settings are clamped rather than refused
   function automatic logic [7:0] div_lim(input logic [7:0] d);
      if (d == 8'h00)
         div_lim = 8'h01;
      else if (d > `RCMS_DIV_MAX)
         div_lim = `RCMS_DIV_MAX;
      else
         div_lim = d;
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // channel dividers
   logic [7:0] ch_cnt [`RCMS_NUM_CH];
   always_ff @(posedge mclk) begin
      for (int c = 0; c < `RCMS_NUM_CH; c++) begin
         if (rst || ch_cnt[c] >= div_lim(channel_output_divider[8*c +: 8]) - 8'h01) begin
            ch_cnt[c]       <= 8'h00;
            channel_tick[c] <= ~rst;
         end else begin
            ch_cnt[c]       <= ch_cnt[c] + 8'h01;
            channel_tick[c] <= 1'b0;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // loss reference tick and input monitors
   logic [8:0] lr_cnt;
   logic       lr_tick;
   always_ff @(posedge mclk) begin
      // powered down: no tick, so only diff_zero can change an input's validity, and only to lost
      if (rst || loss_ref_divider_powerdown) begin
         lr_cnt  <= 9'h000;
         lr_tick <= 1'b0;
      end else if (lr_cnt + 9'h001 >= loss_reference_divider) begin
         lr_cnt  <= 9'h000;
         lr_tick <= 1'b1;
      end else begin
         lr_cnt  <= lr_cnt + 9'h001;
         lr_tick <= 1'b0;
      end
   end

   logic [3:0] lost;
   logic [3:0] lost_q;
   logic [3:0] valid;
   assign valid = ~lost;

   for (genvar g = 0; g < `RCMS_NUM_IN; g++) begin : g_mon
      rcms_in_monitor u_mon (
         .mclk                  (mclk),
         .rst                   (rst),
         .clk_in                (clk_in[g]),
         .diff_zero             (diff_zero[g]),
         .ref_tick              (lr_tick),
         .validation_edge_count (validation_edge_count),
         .lost                  (lost[g])
      );
   end

   //////////////////////////////////////////////////////////////////////////
   // per-input flags
   logic [3:0] armed;
   logic [3:0] loss_event;
   assign loss_event = lost & ~lost_q & armed & {4{~monitor_flag_block}};

   always_ff @(posedge mclk) begin
      if (rst) begin
         lost_q            <= 4'hF;
         armed             <= 4'hF;
         input_loss_status <= 4'h0;
         input_loss_sticky <= 4'h0;
      end else begin
         lost_q            <= lost;
         input_loss_status <= lost & {4{~monitor_flag_block}};
         // set wins over clear; re-armed only once the sticky bit is gone
         input_loss_sticky <= (input_loss_sticky & ~input_loss_clear) | loss_event;
         armed             <= (armed & ~loss_event) | (input_loss_clear & ~loss_event);
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // selection state machine
   rcms_mode_t  mode;
   rcms_state_t state;
   logic [1:0]  sel;
   logic [7:0]  prio_q;
   logic        holdoff_expire;
   logic [2:0]  best;
   logic        sel_ok;
   logic        auto_mode;
   logic        upgrade;

   assign mode      = rcms_mode_t'(selection_mode_field);
   assign best      = best_valid(input_priority, valid);
   assign sel_ok    = valid[sel];
   // bypassed first pll leaves switching undefined; fall back to host select
   assign auto_mode = (mode == RCMS_MODE_AUTO || mode == RCMS_MODE_AUTOHO) && !first_pll_bypass;
   assign upgrade   = !best[2] && prio_of(input_priority, best[1:0]) > prio_of(input_priority, sel)
                      && (revertive_enable || prio_q != input_priority);

   always_ff @(posedge mclk) begin
      if (rst)
         prio_q <= `RCMS_PRIO_RST;
      else
         prio_q <= input_priority;
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         state <= RCMS_NOREF;
         sel   <= `RCMS_SEL_RST;
      end else if (!auto_mode) begin
         sel <= host_select;
         if (valid[host_select])
            state <= RCMS_TRACK;
         else if (mode == RCMS_MODE_SHORT && !first_pll_bypass)
            state <= RCMS_HOLD;
         else
            state <= RCMS_NOREF;
      end else begin
         unique case (state)
            RCMS_TRACK: begin
               if (!sel_ok && mode == RCMS_MODE_AUTOHO) begin
                  state <= RCMS_HOLD;
               end else if (!sel_ok) begin
                  if (!best[2])
                     sel <= best[1:0];
                  else
                     state <= RCMS_NOREF;
               end else if (upgrade) begin
                  sel <= best[1:0];
               end
            end
            RCMS_HOLD: begin
               if (mode == RCMS_MODE_AUTO) begin
                  state <= RCMS_NOREF;
               end else if (holdoff_expire) begin
                  if (sel_ok) begin
                     state <= RCMS_TRACK;
                  end else if (!best[2]) begin
                     sel   <= best[1:0];
                     state <= RCMS_TRACK;
                  end
               end
            end
            RCMS_NOREF: begin
               if (!best[2]) begin
                  sel   <= sel_ok ? sel : best[1:0];
                  state <= RCMS_TRACK;
               end
            end
            default: state <= RCMS_NOREF;
         endcase
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // hold-off prescaler and down-counter
   logic        presc_run;
   logic [17:0] presc_cnt;
   logic        presc_tick;
   logic [7:0]  holdoff_cnt;
   logic        nothing_at_expiry;

   assign presc_run = auto_mode && mode == RCMS_MODE_AUTOHO && state == RCMS_HOLD;

   always_ff @(posedge mclk) begin
      if (rst || !presc_run) begin
         presc_cnt  <= 18'h00000;
         presc_tick <= 1'b0;
      end else if (vcxo_tick && presc_cnt + 18'h00001 >= holdoff_prescaler_ratio) begin
         presc_cnt  <= 18'h00000;
         presc_tick <= 1'b1;
      end else begin
         presc_cnt  <= vcxo_tick ? presc_cnt + 18'h00001 : presc_cnt;
         presc_tick <= 1'b0;
      end
   end

   // a start value of zero expires on the first prescaled tick
   assign holdoff_expire = presc_run && (nothing_at_expiry ? !best[2] : presc_tick && holdoff_cnt == 8'h00);

   always_ff @(posedge mclk) begin
      if (rst || !presc_run) begin
         holdoff_cnt       <= rst ? `RCMS_HOLD_RST : holdoff_start_value;
         nothing_at_expiry <= 1'b0;
      end else if (presc_tick) begin
         if (holdoff_cnt == 8'h00) begin
            holdoff_cnt       <= holdoff_start_value;
            nothing_at_expiry <= best[2];
         end else begin
            holdoff_cnt <= holdoff_cnt - 8'h01;
         end
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // status and holdover word
   logic ref_up;
   assign ref_up = state == RCMS_TRACK;

   always_ff @(posedge mclk) begin
      if (rst) begin
         status             <= '0;
         holdover_freq_word <= 16'h0000;
      end else begin
         status.active_ref_status     <= ref_up;
         status.holdover_active       <= state == RCMS_HOLD;
         status.selected_input_status <= sel;
         // loss wins over the host restore
         if (!ref_up)
            status.active_ref_sticky <= 1'b0;
         else if (active_ref_clear)
            status.active_ref_sticky <= 1'b1;
         if (state == RCMS_TRACK)
            holdover_freq_word <= pll_freq_word;
      end
   end

   //////////////////////////////////////////////////////////////////////////
   // checks
   manual_follow_a: assert property (@(posedge mclk) disable iff (rst)
      (mode == RCMS_MODE_MANUAL) ##1 (mode == RCMS_MODE_MANUAL) |-> sel == $past(host_select))
      else $error("manual selection differs from host select");
   auto_fail_a: assert property (@(posedge mclk) disable iff (rst)
      (auto_mode && mode == RCMS_MODE_AUTO && state == RCMS_TRACK && !sel_ok && !best[2])
      |=> sel == $past(best[1:0]))
      else $error("automatic fail-over target wrong");
   auto_no_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (auto_mode && mode == RCMS_MODE_AUTO) ##1 (mode == RCMS_MODE_AUTO) |-> state != RCMS_HOLD)
      else $error("automatic mode entered holdover");
   short_hold_a: assert property (@(posedge mclk) disable iff (rst)
      (mode == RCMS_MODE_SHORT && !first_pll_bypass && !valid[host_select])
      |=> state == RCMS_HOLD ##1 !status.active_ref_status && !status.active_ref_sticky)
      else $error("short holdover not entered on loss");
   hold_keep_sel_a: assert property (@(posedge mclk) disable iff (rst)
      (state == RCMS_HOLD && !holdoff_expire && auto_mode && mode == RCMS_MODE_AUTOHO) |=> $stable(sel))
      else $error("selection changed before hold-off expiry");
   presc_gate_a: assert property (@(posedge mclk) disable iff (rst)
      !presc_run |=> presc_cnt == 18'h00000 && !presc_tick)
      else $error("prescaler ran outside holdover");
   holdoff_reload_a: assert property (@(posedge mclk) disable iff (rst)
      (presc_tick && holdoff_cnt == 8'h00 && presc_run) |=> holdoff_cnt == $past(holdoff_start_value))
      else $error("hold-off counter not reloaded");
   sticky_rearm_a: assert property (@(posedge mclk) disable iff (rst)
      (input_loss_sticky[0] && !input_loss_clear[0]) |=> !loss_event[0])
      else $error("new loss event while sticky still set");
   block_flags_a: assert property (@(posedge mclk) disable iff (rst)
      monitor_flag_block |=> input_loss_status == 4'h0)
      else $error("status raised while monitor blocked");
   revert_up_a: assert property (@(posedge mclk) disable iff (rst)
      (auto_mode && state == RCMS_TRACK && sel_ok && !upgrade) |=> $stable(sel))
      else $error("selection moved without higher priority");

   fail_over_c: cover property (@(posedge mclk) disable iff (rst)
      state == RCMS_TRACK && auto_mode && !sel_ok && !best[2]);
   expiry_c: cover property (@(posedge mclk) disable iff (rst) holdoff_expire);
   relock_c: cover property (@(posedge mclk) disable iff (rst)
      mode == RCMS_MODE_SHORT && state == RCMS_HOLD ##1 state == RCMS_TRACK);
   revert_c: cover property (@(posedge mclk) disable iff (rst) auto_mode && upgrade && sel_ok);
endmodule

// [rcms_consts.svh]
// constants of the reference clock monitor and selector
// assumes: included by bare name from the package and the design modules
// Functional notes
// - five channel dividers divide the fast clock, each set from 1 to 160
// - three consecutive missed input edges against the loss tick mark an input lost
// - monitor block high keeps the monitor from raising any status flag
// - a zero differential input voltage also counts as loss
// - a lost input becomes valid after the validation count of good periods
// - manual mode follows host select; lost selection unlocks, revalidation relocks
// - automatic mode fails over at once to the best priority valid input
// - automatic mode with nothing valid stays unlocked, no holdover, locks on revalidation
// - short holdover mode follows host select, holds over on loss, relocks on revalidation
// - automatic holdover mode holds over, counts down, fails over at expiry
// - automatic holdover with nothing valid stays in holdover until an input revalidates
// - each input has priority 0 to 3; changes may reselect at once in automatic modes
// - hold-off count starts when the active flag falls; zero means expiry and reselect
// - eight bit hold-off count runs on the prescaled vcxo tick from its start value
// - after expiry the hold-off count reloads its start value
// - an input raises no new loss event until its sticky bit is cleared
// - the prescaler runs only in automatic holdover while in the holdover state
// - revertive switching, off by default, moves only to a strictly higher priority
// - short holdover loss: holdover on, active and sticky low, selection kept, no countdown
// - short holdover recovery: holdover off, active high, sticky restored by host write
// - in holdover the frequency word is the one frozen before the loss
`ifndef RCMS_CONSTS_SVH
`define RCMS_CONSTS_SVH

`define RCMS_NUM_IN        4
`define RCMS_NUM_CH        5
`define RCMS_DIV_MAX       8'hA0
`define RCMS_MISS_LIMIT    2'h3
`define RCMS_PRIO_RST      8'h00
`define RCMS_HOLD_RST      8'h00
`define RCMS_SEL_RST       2'h0

`endif

// [rcms_pkg.sv]
// types of the reference clock monitor and selector
// assumes: compiled before every design module
package rcms_pkg;
   `include "rcms_consts.svh"

   typedef enum logic [1:0] {
      RCMS_MODE_MANUAL = 2'h0,
      RCMS_MODE_AUTO   = 2'h1,
      RCMS_MODE_SHORT  = 2'h2,
      RCMS_MODE_AUTOHO = 2'h3
   } rcms_mode_t;

   typedef enum logic [2:0] {
      RCMS_TRACK = 3'h1,
      RCMS_HOLD  = 3'h2,
      RCMS_NOREF = 3'h4
   } rcms_state_t;

   typedef struct packed {
      logic       active_ref_status;
      logic       active_ref_sticky;
      logic       holdover_active;
      logic [1:0] selected_input_status;
   } rcms_status_t;
endpackage

// [rcms_in_monitor.sv]
// one input activity monitor: missed-edge count and re-validation
// assumes: clk_in sampled as a level synchronous to mclk, ref_tick a one-cycle enable
`timescale 1ns/1ps
`include "rcms_consts.svh"
module rcms_in_monitor
   import rcms_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rst,
   // input under watch
   input  wire logic       clk_in,
   input  wire logic       diff_zero,
   input  wire logic       ref_tick,
   input  wire logic [7:0] validation_edge_count,
   // result
   output logic            lost
);
   logic       prev_in;
   logic       edge_seen;
   logic [1:0] miss_cnt;
   logic [7:0] good_cnt;

   always_ff @(posedge mclk) begin
      if (rst) begin
         prev_in   <= 1'b0;
         edge_seen <= 1'b0;
      end else begin
         prev_in <= clk_in;
         if (ref_tick)
            edge_seen <= clk_in & ~prev_in;
         else if (clk_in & ~prev_in)
            edge_seen <= 1'b1;
      end
   end

   // inputs start lost so that none is used before it has proved itself
   always_ff @(posedge mclk) begin
      if (rst) begin
         miss_cnt <= 2'h0;
         good_cnt <= 8'h00;
         lost     <= 1'b1;
      end else if (diff_zero) begin
         miss_cnt <= 2'h0;
         good_cnt <= 8'h00;
         lost     <= 1'b1;
      end else if (ref_tick) begin
         if (edge_seen) begin
            miss_cnt <= 2'h0;
            if (lost) begin
               if (good_cnt + 8'h01 >= validation_edge_count) begin
                  good_cnt <= 8'h00;
                  lost     <= 1'b0;
               end else begin
                  good_cnt <= good_cnt + 8'h01;
               end
            end
         end else begin
            good_cnt <= 8'h00;
            if (miss_cnt == `RCMS_MISS_LIMIT - 2'h1)
               lost <= 1'b1;
            if (miss_cnt != `RCMS_MISS_LIMIT)
               miss_cnt <= miss_cnt + 2'h1;
         end
      end
   end

   logic [1:0] quiet_ticks;
   always_ff @(posedge mclk) begin
      if (rst)
         quiet_ticks <= 2'h0;
      else if (diff_zero)
         quiet_ticks <= 2'h0;
      else if (ref_tick)
         quiet_ticks <= edge_seen ? 2'h0 : (quiet_ticks == 2'h3 ? 2'h3 : quiet_ticks + 2'h1);
   end

   three_miss_a: assert property (@(posedge mclk) disable iff (rst)
      (quiet_ticks == 2'h3) |-> lost)
      else $error("input not lost after three missed edges");
   diff_zero_a: assert property (@(posedge mclk) disable iff (rst)
      diff_zero |=> lost)
      else $error("zero differential input not flagged");
   revalid_a: assert property (@(posedge mclk) disable iff (rst)
      $fell(lost) |-> $past(ref_tick) && $past(edge_seen))
      else $error("input revalidated without a counted edge");
endmodule

// [rcms_clk_src.sv]
// four reference clock sources that feed the monitored inputs
// assumes: run bits change just after mclk edges; a stopped source holds a static level
`timescale 1ns/1ps
module rcms_clk_src
   import rcms_pkg::*;
   #(parameter int HALF = 2)
(
   // clock
   input  wire logic       mclk,
   // source control
   input  wire logic [3:0] run,
   // clocks into the block
   output logic      [3:0] clk_out
);
   int cnt = 0;

   initial clk_out = 4'h5;

   // a stopped source freezes rather than floating: a dead oscillator looks static
   always @(posedge mclk) begin
      cnt = (cnt + 1) % HALF;
      if (cnt == 0) clk_out <= clk_out ^ run;
   end
endmodule

// [rcms_top_tb_top.sv]
// self-checking bench of the reference clock monitor and selector
// assumes: rcms_pkg, rcms_top and rcms_clk_src compiled before it
`timescale 1ns/1ps
module rcms_top_tb_top
   import rcms_pkg::*;
;
   logic         mclk = 1'b0, rst = 1'b1, blk = 1'b0, arclr = 1'b0, rev = 1'b0, vtick = 1'b0;
   logic  [3:0]  run = 4'hF, clk_in, dz = 4'h0, lclr = 4'h0, lstat, lsticky;
   logic  [1:0]  mode = 2'h0, hsel = 2'h1;
   logic  [7:0]  prio = 8'h2D, hsv = 8'h03;
   logic [15:0]  pword = 16'h0000, hword, hw;
   logic [39:0]  cdiv;
   logic  [4:0]  ctick;
   rcms_status_t status;
   int           fail_count = 0, comparisons = 0, seed = 32'h606a5a5a, n, dv[5];

   rcms_clk_src SRC (.mclk, .run, .clk_out(clk_in));
   // divider powered on, ratio of 8 spanning two source periods
   // first pll never bypassed, so every selection mode stays defined
   rcms_top DUT (.mclk, .rst, .clk_in, .diff_zero(dz), .loss_reference_divider(9'h008),
      .loss_ref_divider_powerdown(1'b0), .validation_edge_count(8'h04), .monitor_flag_block(blk),
      .selection_mode_field(mode), .host_select(hsel), .input_priority(prio),
      .revertive_enable(rev), .first_pll_bypass(1'b0), .vcxo_tick(vtick),
      .holdoff_prescaler_ratio(18'h00004), .holdoff_start_value(hsv), .input_loss_clear(lclr),
      .active_ref_clear(arclr), .pll_freq_word(pword), .holdover_freq_word(hword), .status,
      .input_loss_status(lstat), .input_loss_sticky(lsticky), .channel_output_divider(cdiv),
      .channel_tick(ctick));

   always #4 mclk = ~mclk;

   always @(posedge mclk) begin
      vtick <= 1'($random(seed));
      pword <= 16'($random(seed));
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task tick(int k);
      repeat (k) @(posedge mclk);
   endtask

   task src(int k, logic v);
      @(posedge mclk);
      run[k] <= v;
   endtask

   // sticky bits cleared on every mode change so each input is armed again
   task setm(logic [1:0] m, logic [1:0] h);
      @(posedge mclk);
      mode <= m;
      hsel <= h;
      lclr <= 4'hF;
      @(posedge mclk);
      lclr <= 4'h0;
      @(posedge mclk);
   endtask

   // host write of 1 that restores the good flag
   task ref_clear;
      @(posedge mclk);
      arclr <= 1'b1;
      @(posedge mclk);
      arclr <= 1'b0;
      tick(2);
   endtask

   task wait_hold(logic v);
      for (int k = 0; k < 400 && status.holdover_active !== v; k++) @(posedge mclk);
   endtask

   task wait_sel(logic [1:0] v);
      for (int k = 0; k < 400 && status.selected_input_status !== v; k++) @(posedge mclk);
   endtask

   task summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge mclk);
      fail_count++;
      summarize;
   end

   initial begin
      for (int c = 0; c < 5; c++) dv[c] = (c == 0) ? 1 : (c == 4) ? 160 : 2 + ($random(seed) & 127);
      for (int c = 0; c < 5; c++) cdiv[8*c +: 8] = 8'(dv[c]);
      tick(11);
      chk("reset status", 16'(status), 16'h0000);
      chk("reset sticky", 16'(lsticky), 16'h0000);
      @(posedge mclk);
      rst <= 1'b0;
      tick(80);
      chk("revalidated", 16'(lstat), 16'h0000);
      chk("manual sel", 16'(status.selected_input_status), 16'h0001);
      chk("manual active", 16'(status.active_ref_status), 16'h0001);
      src(1, 1'b0);
      tick(48);
      chk("loss status", 16'(lstat), 16'h0002);
      chk("loss sticky", 16'(lsticky), 16'h0002);
      chk("manual sel kept", 16'(status.selected_input_status), 16'h0001);
      chk("manual unlock", 16'(status.active_ref_status), 16'h0000);
      src(1, 1'b1);
      tick(80);
      chk("loss cleared", 16'(lstat), 16'h0000);
      chk("manual relock", 16'(status.active_ref_status), 16'h0001);
      setm(2'h0, 2'h1);
      chk("sticky cleared", 16'(lsticky), 16'h0000);
      $display("test manual done");
      setm(2'h1, 2'h0);
      wait_sel(2'h1);
      src(1, 1'b0);
      wait_sel(2'h2);
      chk("auto failover", 16'(status.selected_input_status), 16'h0002);
      chk("auto no hold", 16'(status.holdover_active), 16'h0000);
      src(1, 1'b1);
      tick(80);
      chk("no revert", 16'(status.selected_input_status), 16'h0002);
      prio <= 8'hE4;
      tick(4);
      chk("prio change", 16'(status.selected_input_status), 16'h0003);
      prio <= 8'h2D;
      dz <= 4'h1;
      tick(8);
      chk("diff zero", 16'(lstat), 16'h0001);
      dz <= 4'h0;
      tick(80);
      $display("test auto done");
      setm(2'h2, 2'h2);
      wait_sel(2'h2);
      tick(4);
      ref_clear;
      chk("ref sticky set", 16'(status.active_ref_sticky), 16'h0001);
      src(2, 1'b0);
      wait_hold(1'b1);
      hw = hword;
      chk("short hold", 16'(status.holdover_active), 16'h0001);
      chk("short sel", 16'(status.selected_input_status), 16'h0002);
      chk("short active", 16'({status.active_ref_status, status.active_ref_sticky}), 16'h0000);
      tick(20);
      chk("frozen word", hword, hw);
      src(2, 1'b1);
      wait_hold(1'b0);
      tick(2);
      chk("short relock", 16'(status.active_ref_status), 16'h0001);
      ref_clear;
      chk("ref sticky", 16'(status.active_ref_sticky), 16'h0001);
      $display("test short holdover done");
      hsv <= 8'($random(seed) & 7) | 8'h01;
      rev <= 1'b1;
      setm(2'h3, 2'h0);
      wait_sel(2'h1);
      chk("revertive up", 16'(status.selected_input_status), 16'h0001);
      src(1, 1'b0);
      wait_hold(1'b1);
      chk("autoho hold", 16'(status.holdover_active), 16'h0001);
      chk("autoho defer", 16'(status.selected_input_status), 16'h0001);
      wait_sel(2'h2);
      chk("expiry sel", 16'(status.selected_input_status), 16'h0002);
      tick(2);
      chk("autoho track", 16'(status.holdover_active), 16'h0000);
      @(posedge mclk);
      run <= 4'h0;
      tick(300);
      chk("none valid", 16'(status.holdover_active), 16'h0001);
      src(0, 1'b1);
      wait_sel(2'h0);
      chk("relock first", 16'(status.selected_input_status), 16'h0000);
      $display("test auto holdover done");
      setm(2'h0, 2'h0);
      run <= 4'hF;
      blk <= 1'b1;
      tick(80);
      src(3, 1'b0);
      tick(48);
      chk("blocked", 16'({lstat, lsticky}), 16'h0000);
      blk <= 1'b0;
      tick(3);
      chk("unblocked", 16'(lstat), 16'h0008);
      $display("test monitor block done");
      for (int c = 0; c < 5; c++) begin
         for (n = 0; n < 200 && ctick[c] !== 1'b1; n++) @(posedge mclk);
         @(posedge mclk);
         for (n = 1; n < 200 && ctick[c] !== 1'b1; n++) @(posedge mclk);
         chk("divider period", 16'(n), 16'(dv[c]));
      end
      $display("test dividers done");
      summarize;
   end
endmodule
